// file: pfs_synth.sv
// phase accumulator frequency synthesizer with apb register access
//
// Functional notes
// RULE1: 20-bit accumulator adds increment each input edge
// RULE2: adder carry out is the overflow event
// RULE3: two-bit select picks fast osc, fosc, logic cell
// RULE4: accumulator readable, writable as three bytes
// RULE5: adder steps only on selected input clock
// RULE6: increment held in low, high, upper registers
// RULE7: enabled low write loads buffer second edge
// RULE8: software writes upper, high before low
// RULE9: disabled increment writes load buffer immediately
// RULE10: increment registers accessible, working buffer hidden
// RULE11: fixed duty mode toggles output per overflow
// RULE12: pulse mode goes active at next edge
// RULE13: three-bit field selects pulse width
// RULE14: pulse width beyond overflow interval undefined
// RULE15: polarity applied after duty or pulse logic
// RULE16: polarity change with interrupts enabled interrupts
// RULE17: output status readable, routed to peripherals, pin
// RULE18: each overflow sets overflow interrupt flag
// RULE19: interrupt needs all four enable bits set
// RULE20: flag stays set until software clears
// RULE21: reset clears every register to zero
// RULE22: runs in sleep, keeps fast osc on
// RULE23: module enable bit turns module on
// RULE24: polarity bit set inverts the output
// RULE25: disabled module holds, no events, inactive output
// RULE26: input clocks synchronised, no overflow lost
`timescale 1ns/1ps
module pfs_synth import pfs_pkg::*; #(
  parameter int unsigned ACC_W = PFS_ACC_W
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [PFS_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic internal_fast_osc,
  input wire logic logic_cell_one_output,
  output logic synth_out,
  output logic synth_pin_out,
  output logic synth_pin_oe,
  output logic overflow_irq,
  output logic keep_fast_osc_on
);

  pfs_control_type ctrl_q;
  pfs_clock_config_type clk_cfg_q;
  pfs_irq_control_type irq_ctl_q;
  logic overflow_irq_flag_q;
  logic overflow_irq_enable_q;
  logic [ACC_W-1:0] accum_q;
  logic [ACC_W-1:0] incr_q;
  logic [ACC_W-1:0] incr_buf_q;
  logic [1:0] load_cnt_q;
  logic raw_out_q;
  logic pf_start_q;
  logic [7:0] pf_cnt_q;
  logic out_q;
  logic pready_q;
  logic pslverr_q;
  logic [31:0] prdata_q;
  logic irq_q;
  logic pin_out_q;
  logic pin_oe_q;
  logic keep_osc_q;

  // ---------------- input clock selection ----------------
  logic [1:0] ext_clk;
  logic [1:0] ext_rise;
  logic tick;

  assign ext_clk = {logic_cell_one_output, internal_fast_osc};

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_src
      pfs_edge_sync u_sync ( // [RULE26]
        .pclk(pclk),
        .presetn(presetn),
        .async_in(ext_clk[g]),
        .rise(ext_rise[g])
      );
    end
  endgenerate

  // fosc is pclk itself, so it steps every cycle; the external sources can
  // step at most every other cycle, which bounds them to below pclk/2
  always_comb begin
    case (clk_cfg_q.clock_source_select) // [RULE3]
      PFS_SRC_FAST_OSC: tick = ext_rise[0];
      PFS_SRC_FOSC: tick = 1'b1;
      PFS_SRC_LOGIC_CELL: tick = ext_rise[1];
      PFS_SRC_NONE: tick = 1'b0;
      default: tick = 1'b0;
    endcase
  end

  // ---------------- apb decode ----------------
  logic acc_phase;
  logic wr_en;
  logic rd_en;
  logic addr_ok;
  logic [7:0] wbyte;

  assign acc_phase = psel & penable & pready_q;
  assign wr_en = acc_phase & pwrite;
  assign rd_en = acc_phase & ~pwrite;
  assign wbyte = pwdata[7:0];

  function automatic logic hit(input logic [PFS_ADDR_W-1:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction : hit

  always_comb begin
    case (paddr)
      PFS_OFF_SYNTH_CONTROL, PFS_OFF_SYNTH_CLOCK_CONFIG, PFS_OFF_ACCUM_LOW,
      PFS_OFF_ACCUM_HIGH, PFS_OFF_ACCUM_UPPER, PFS_OFF_INCR_LOW, PFS_OFF_INCR_HIGH,
      PFS_OFF_INCR_UPPER, PFS_OFF_PERIPH_IRQ_REQUEST_2, PFS_OFF_PERIPH_IRQ_ENABLE_2,
      PFS_OFF_IRQ_CONTROL: addr_ok = 1'b1;
      default: addr_ok = 1'b0;
    endcase
  end

  logic [7:0] ctrl_rd;
  logic [7:0] rd_byte;

  always_comb begin
    ctrl_rd = 8'h00;
    ctrl_rd[PFS_BIT_MODULE_ENABLE] = ctrl_q.module_enable;
    ctrl_rd[PFS_BIT_OUTPUT_STATUS] = out_q; // [RULE17]
    ctrl_rd[PFS_BIT_OUTPUT_POLARITY] = ctrl_q.output_polarity;
    ctrl_rd[PFS_BIT_PULSE_MODE_SELECT] = ctrl_q.pulse_mode_select;
    rd_byte = 8'h00;
    case (paddr)
      PFS_OFF_SYNTH_CONTROL: rd_byte = ctrl_rd;
      PFS_OFF_SYNTH_CLOCK_CONFIG: begin
        rd_byte[PFS_LSB_PULSE_WIDTH_SELECT +: 3] = clk_cfg_q.pulse_width_select;
        rd_byte[PFS_BIT_PIN_ENABLE] = clk_cfg_q.pin_enable;
        rd_byte[PFS_LSB_CLOCK_SOURCE_SELECT +: 2] = clk_cfg_q.clock_source_select;
      end
      PFS_OFF_ACCUM_LOW: rd_byte = accum_q[7:0]; // [RULE4]
      PFS_OFF_ACCUM_HIGH: rd_byte = accum_q[15:8];
      PFS_OFF_ACCUM_UPPER: rd_byte = {4'h0, accum_q[19:16]};
      PFS_OFF_INCR_LOW: rd_byte = incr_q[7:0]; // [RULE10]
      PFS_OFF_INCR_HIGH: rd_byte = incr_q[15:8];
      PFS_OFF_INCR_UPPER: rd_byte = {4'h0, incr_q[19:16]};
      PFS_OFF_PERIPH_IRQ_REQUEST_2: rd_byte[PFS_BIT_OVERFLOW_IRQ_FLAG] = overflow_irq_flag_q;
      PFS_OFF_PERIPH_IRQ_ENABLE_2: rd_byte[PFS_BIT_OVERFLOW_IRQ_ENABLE] = overflow_irq_enable_q;
      PFS_OFF_IRQ_CONTROL: begin
        rd_byte[PFS_BIT_GLOBAL_IRQ_ENABLE] = irq_ctl_q.global_irq_enable;
        rd_byte[PFS_BIT_PERIPHERAL_IRQ_ENABLE] = irq_ctl_q.peripheral_irq_enable;
      end
      default: rd_byte = 8'h00;
    endcase
  end

  // one wait state: pready rises the cycle after the access phase starts
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h00000000;
    end else begin
      pready_q <= psel & penable & ~pready_q;
      pslverr_q <= psel & penable & ~pready_q & ~addr_ok;
      if (psel & penable & ~pready_q & ~pwrite) begin
        prdata_q <= {24'h000000, rd_byte};
      end
    end
  end

  // ---------------- configuration registers ----------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin // [RULE21]
      ctrl_q <= '0;
      clk_cfg_q <= '0;
      irq_ctl_q <= '0;
      overflow_irq_enable_q <= 1'b0;
    end else if (wr_en) begin
      if (hit(paddr, PFS_OFF_SYNTH_CONTROL)) begin
        ctrl_q.module_enable <= wbyte[PFS_BIT_MODULE_ENABLE]; // [RULE23]
        ctrl_q.output_polarity <= wbyte[PFS_BIT_OUTPUT_POLARITY];
        ctrl_q.pulse_mode_select <= wbyte[PFS_BIT_PULSE_MODE_SELECT];
      end
      if (hit(paddr, PFS_OFF_SYNTH_CLOCK_CONFIG)) begin
        clk_cfg_q.pulse_width_select <= wbyte[PFS_LSB_PULSE_WIDTH_SELECT +: 3]; // [RULE13]
        clk_cfg_q.pin_enable <= wbyte[PFS_BIT_PIN_ENABLE];
        clk_cfg_q.clock_source_select <=
          pfs_source_type'(wbyte[PFS_LSB_CLOCK_SOURCE_SELECT +: 2]);
      end
      if (hit(paddr, PFS_OFF_PERIPH_IRQ_ENABLE_2)) begin
        overflow_irq_enable_q <= wbyte[PFS_BIT_OVERFLOW_IRQ_ENABLE];
      end
      if (hit(paddr, PFS_OFF_IRQ_CONTROL)) begin
        irq_ctl_q.global_irq_enable <= wbyte[PFS_BIT_GLOBAL_IRQ_ENABLE];
        irq_ctl_q.peripheral_irq_enable <= wbyte[PFS_BIT_PERIPHERAL_IRQ_ENABLE];
      end
    end
  end

  // ---------------- increment and its hidden buffer ----------------
  logic incr_wr;
  logic incr_wr_q;

  assign incr_wr = wr_en & (hit(paddr, PFS_OFF_INCR_LOW) | hit(paddr, PFS_OFF_INCR_HIGH) |
                            hit(paddr, PFS_OFF_INCR_UPPER));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      incr_q <= PFS_RESET_WORD;
    end else if (wr_en) begin
      if (hit(paddr, PFS_OFF_INCR_LOW)) incr_q[7:0] <= wbyte; // [RULE6]
      if (hit(paddr, PFS_OFF_INCR_HIGH)) incr_q[15:8] <= wbyte;
      if (hit(paddr, PFS_OFF_INCR_UPPER)) incr_q[19:16] <= wbyte[3:0];
    end
  end

  // a transfer pending while another low write arrives restarts the count
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      load_cnt_q <= 2'h0;
    end else if (!ctrl_q.module_enable) begin
      load_cnt_q <= 2'h0;
    end else if (wr_en && hit(paddr, PFS_OFF_INCR_LOW)) begin
      load_cnt_q <= PFS_INCR_LOAD_EDGES; // [RULE7]
    end else if (tick && load_cnt_q != 2'h0) begin
      load_cnt_q <= load_cnt_q - 2'h1;
    end
  end

  // working buffer has no read path; it only feeds the adder
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      incr_wr_q <= 1'b0;
      incr_buf_q <= PFS_RESET_WORD;
    end else begin
      // disabled copy waits a cycle so the byte just written is already in incr_q
      incr_wr_q <= incr_wr; // [RULE9]
      if (ctrl_q.module_enable ? (tick && load_cnt_q == 2'h1) : incr_wr_q) begin // [RULE7]
        incr_buf_q <= incr_q;
      end
    end
  end

  // ---------------- accumulator ----------------
  logic [ACC_W:0] sum;
  logic carry_event;

  assign sum = {1'b0, accum_q} + {1'b0, incr_buf_q}; // [RULE1]
  assign carry_event = ctrl_q.module_enable & tick & sum[ACC_W]; // [RULE2] [RULE25]

  // a software byte write wins over an addition in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      accum_q <= PFS_RESET_WORD;
    end else if (wr_en && hit(paddr, PFS_OFF_ACCUM_LOW)) begin
      accum_q[7:0] <= wbyte; // [RULE4]
    end else if (wr_en && hit(paddr, PFS_OFF_ACCUM_HIGH)) begin
      accum_q[15:8] <= wbyte;
    end else if (wr_en && hit(paddr, PFS_OFF_ACCUM_UPPER)) begin
      accum_q[19:16] <= wbyte[3:0];
    end else if (ctrl_q.module_enable && tick) begin // [RULE5] [RULE22]
      accum_q <= sum[ACC_W-1:0];
    end
  end

  // ---------------- duty / pulse shaping ----------------
  logic [7:0] pf_width;

  assign pf_width = 8'h01 << clk_cfg_q.pulse_width_select; // [RULE13]

  // widths longer than the overflow interval give an undefined shape [RULE14]
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      raw_out_q <= 1'b0;
      pf_start_q <= 1'b0;
      pf_cnt_q <= 8'h00;
    end else if (!ctrl_q.module_enable) begin
      raw_out_q <= 1'b0; // [RULE25]
      pf_start_q <= 1'b0;
      pf_cnt_q <= 8'h00;
    end else if (!ctrl_q.pulse_mode_select) begin
      pf_start_q <= 1'b0;
      pf_cnt_q <= 8'h00;
      if (carry_event) raw_out_q <= ~raw_out_q; // [RULE11]
    end else begin
      if (carry_event) begin
        pf_start_q <= 1'b1;
      end else if (tick) begin
        pf_start_q <= 1'b0;
      end
      if (tick && pf_start_q) begin
        raw_out_q <= 1'b1; // [RULE12]
        pf_cnt_q <= pf_width;
      end else if (tick && pf_cnt_q != 8'h00) begin
        pf_cnt_q <= pf_cnt_q - 8'h01;
        if (pf_cnt_q == 8'h01) raw_out_q <= 1'b0;
      end
    end
  end

  logic out_d;

  assign out_d = raw_out_q ^ ctrl_q.output_polarity; // [RULE15] [RULE24]

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_q <= 1'b0;
      pin_out_q <= 1'b0;
      pin_oe_q <= 1'b0;
    end else begin
      out_q <= out_d; // [RULE17]
      pin_out_q <= out_d;
      pin_oe_q <= clk_cfg_q.pin_enable;
    end
  end

  // ---------------- interrupt ----------------
  logic pol_change;
  logic irq_enabled;

  assign irq_enabled = ctrl_q.module_enable & overflow_irq_enable_q &
                       irq_ctl_q.peripheral_irq_enable & irq_ctl_q.global_irq_enable;
  assign pol_change = wr_en & hit(paddr, PFS_OFF_SYNTH_CONTROL) & irq_enabled &
                      (wbyte[PFS_BIT_OUTPUT_POLARITY] != ctrl_q.output_polarity); // [RULE16]

  // set wins over a software clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      overflow_irq_flag_q <= 1'b0;
    end else if (carry_event || pol_change) begin
      overflow_irq_flag_q <= 1'b1; // [RULE18]
    end else if (wr_en && hit(paddr, PFS_OFF_PERIPH_IRQ_REQUEST_2)) begin
      overflow_irq_flag_q <= wbyte[PFS_BIT_OVERFLOW_IRQ_FLAG]; // [RULE20]
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_q <= 1'b0;
      keep_osc_q <= 1'b0;
    end else begin
      irq_q <= overflow_irq_flag_q & irq_enabled; // [RULE19]
      keep_osc_q <= ctrl_q.module_enable &
                    (clk_cfg_q.clock_source_select == PFS_SRC_FAST_OSC); // [RULE22]
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign synth_out = out_q;
  assign synth_pin_out = pin_out_q;
  assign synth_pin_oe = pin_oe_q;
  assign overflow_irq = irq_q;
  assign keep_fast_osc_on = keep_osc_q;

endmodule : pfs_synth

// file: pfs_pkg.sv
// package for the phase accumulator frequency synthesizer: map, fields, types
package pfs_pkg;

  localparam int unsigned PFS_ACC_W = 20;
  localparam int unsigned PFS_ADDR_W = 8;

  // register byte addresses
  localparam logic [7:0] PFS_OFF_SYNTH_CONTROL = 8'h00;
  localparam logic [7:0] PFS_OFF_SYNTH_CLOCK_CONFIG = 8'h04;
  localparam logic [7:0] PFS_OFF_ACCUM_LOW = 8'h08;
  localparam logic [7:0] PFS_OFF_ACCUM_HIGH = 8'h0c;
  localparam logic [7:0] PFS_OFF_ACCUM_UPPER = 8'h10;
  localparam logic [7:0] PFS_OFF_INCR_LOW = 8'h14;
  localparam logic [7:0] PFS_OFF_INCR_HIGH = 8'h18;
  localparam logic [7:0] PFS_OFF_INCR_UPPER = 8'h1c;
  localparam logic [7:0] PFS_OFF_PERIPH_IRQ_REQUEST_2 = 8'h20;
  localparam logic [7:0] PFS_OFF_PERIPH_IRQ_ENABLE_2 = 8'h24;
  localparam logic [7:0] PFS_OFF_IRQ_CONTROL = 8'h28;

  // synth_control fields
  localparam int unsigned PFS_BIT_MODULE_ENABLE = 7;
  localparam int unsigned PFS_BIT_OUTPUT_STATUS = 5;
  localparam int unsigned PFS_BIT_OUTPUT_POLARITY = 4;
  localparam int unsigned PFS_BIT_PULSE_MODE_SELECT = 0;
  // synth_clock_config fields
  localparam int unsigned PFS_LSB_PULSE_WIDTH_SELECT = 5;
  localparam int unsigned PFS_BIT_PIN_ENABLE = 3;
  localparam int unsigned PFS_LSB_CLOCK_SOURCE_SELECT = 0;
  // interrupt register fields
  localparam int unsigned PFS_BIT_OVERFLOW_IRQ_FLAG = 0;
  localparam int unsigned PFS_BIT_OVERFLOW_IRQ_ENABLE = 0;
  localparam int unsigned PFS_BIT_GLOBAL_IRQ_ENABLE = 7;
  localparam int unsigned PFS_BIT_PERIPHERAL_IRQ_ENABLE = 6;

  // every register clears to zero
  localparam logic [7:0] PFS_RESET_BYTE = 8'h00;
  localparam logic [19:0] PFS_RESET_WORD = 20'h00000;

  // increment transfer lands on this input-clock edge after the low write
  localparam logic [1:0] PFS_INCR_LOAD_EDGES = 2'h2;

  typedef enum logic [1:0] {
    PFS_SRC_FAST_OSC = 2'b00,
    PFS_SRC_FOSC = 2'b01,
    PFS_SRC_LOGIC_CELL = 2'b10,
    PFS_SRC_NONE = 2'b11
  } pfs_source_type;

  typedef struct packed {
    logic module_enable;
    logic output_polarity;
    logic pulse_mode_select;
  } pfs_control_type;

  typedef struct packed {
    logic [2:0] pulse_width_select;
    logic pin_enable;
    pfs_source_type clock_source_select;
  } pfs_clock_config_type;

  typedef struct packed {
    logic global_irq_enable;
    logic peripheral_irq_enable;
  } pfs_irq_control_type;

endpackage : pfs_pkg

// file: pfs_edge_sync.sv
// synchroniser and rising-edge detector for one external clock source
`timescale 1ns/1ps
module pfs_edge_sync (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic async_in,
  output logic rise
);
  logic meta_q;
  logic sync_q;
  logic last_q;

  // meta_q feeds only sync_q
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      last_q <= 1'b0;
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
      last_q <= sync_q;
    end
  end

  assign rise = sync_q & ~last_q;
endmodule : pfs_edge_sync

// file: pfs_synth_monitor.sv
// assertion checker on the synthesizer top-level ports, bound below
`timescale 1ns/1ps
module pfs_synth_monitor import pfs_pkg::*; #(
  parameter int unsigned ACC_W = PFS_ACC_W
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [PFS_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic internal_fast_osc,
  input wire logic logic_cell_one_output,
  input wire logic synth_out,
  input wire logic synth_pin_out,
  input wire logic synth_pin_oe,
  input wire logic overflow_irq,
  input wire logic keep_fast_osc_on
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  logic wr;
  logic [7:0] ctrl_q;
  logic [7:0] cfg_q;
  logic [7:0] ien_q;
  logic [7:0] ictl_q;
  logic [1:0] quiet_q;
  assign wr = psel && penable && pready && pwrite;
  // shadow of the written bytes; the checker never reads the design back
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= 8'h00;
      cfg_q <= 8'h00;
      ien_q <= 8'h00;
      ictl_q <= 8'h00;
    end else if (wr) begin
      case (paddr)
        PFS_OFF_SYNTH_CONTROL: ctrl_q <= pwdata[7:0];
        PFS_OFF_SYNTH_CLOCK_CONFIG: cfg_q <= pwdata[7:0];
        PFS_OFF_PERIPH_IRQ_ENABLE_2: ien_q <= pwdata[7:0];
        PFS_OFF_IRQ_CONTROL: ictl_q <= pwdata[7:0];
        default: ;
      endcase
    end
  end
  // cycles since a control write, so the output is not judged while it settles
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      quiet_q <= 2'h0;
    end else if (wr && (paddr == PFS_OFF_SYNTH_CONTROL)) begin
      quiet_q <= 2'h0;
    end else if (quiet_q != 2'h3) begin
      quiet_q <= quiet_q + 2'h1;
    end
  end
  AST_PREADY_WAIT: assert property ($rose(psel && penable) |-> !pready ##1 pready)
    else $error("pready not after one wait state");
  AST_PREADY_PULSE: assert property (pready |-> psel && penable ##1 !pready)
    else $error("pready not a single access pulse");
  AST_SLVERR_MAP: assert property (pready && (paddr[1:0] == 2'b00) |->
    pslverr == (paddr > PFS_OFF_IRQ_CONTROL)) else $error("pslverr wrong for address");
  AST_RDATA_BYTE: assert property (pready && !pwrite |-> prdata[31:8] == 24'h0)
    else $error("read data above byte not zero");
  AST_PIN_FOLLOWS: assert property (synth_pin_out == synth_out)
    else $error("pin output differs from output");
  AST_PIN_OE_LAG: assert property (synth_pin_oe == $past(cfg_q[PFS_BIT_PIN_ENABLE]))
    else $error("pin enable does not follow its bit");
  AST_IRQ_GATED: assert property (overflow_irq |->
    $past(ctrl_q[7] && ien_q[0] && ictl_q[7] && ictl_q[6]))
    else $error("interrupt without all enables");
  AST_KEEP_OSC: assert property ((ctrl_q[7] && cfg_q[1:0] == 2'b00) ==
    $past(ctrl_q[7] && cfg_q[1:0] == 2'b00) |->
    keep_fast_osc_on == (ctrl_q[7] && cfg_q[1:0] == 2'b00))
    else $error("oscillator keep request wrong");
  AST_IDLE_LEVEL: assert property (!ctrl_q[7] && quiet_q == 2'h3 |->
    synth_out == ctrl_q[4]) else $error("disabled output not at inactive level");
endmodule : pfs_synth_monitor
bind pfs_synth pfs_synth_monitor #(.ACC_W(ACC_W)) pfs_synth_monitor_i (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .internal_fast_osc(internal_fast_osc), .logic_cell_one_output(logic_cell_one_output),
  .synth_out(synth_out), .synth_pin_out(synth_pin_out), .synth_pin_oe(synth_pin_oe),
  .overflow_irq(overflow_irq), .keep_fast_osc_on(keep_fast_osc_on)
);

// file: pfs_far_side.sv
// far-side model: oscillator and logic-cell clock sources
`timescale 1ns/1ps
module pfs_far_side (
  input wire logic pclk,
  input wire logic presetn,
  output logic internal_fast_osc,
  output logic logic_cell_one_output
);
  logic [2:0] div_q;
  // derived from pclk so counts are exact; both stay below pclk/2 as the synchronisers need
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_q <= 3'h0;
    end else begin
      div_q <= div_q + 3'h1;
    end
  end
  assign internal_fast_osc = div_q[1];
  assign logic_cell_one_output = div_q[2];
endmodule : pfs_far_side

// file: phase_accum_freq_synth_tb_top.sv
// testbench for the synthesizer: apb tasks and output measurements
`timescale 1ns/1ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin fail_count++; \
  $display("unexpected at %0t got %h exp %h", $time, g, e); end end
module phase_accum_freq_synth_tb_top import pfs_pkg::*;;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, internal_fast_osc, logic_cell_one_output;
  logic synth_out, synth_pin_out, synth_pin_oe, overflow_irq, keep_fast_osc_on;
  logic [31:0] rd_q;
  logic err;
  int fail_count = 0;
  int checked = 0;
  int tog, act;
  int src_tog [4] = '{4, 16, 2, 0};
  always #5 pclk = ~pclk;
  pfs_synth pfs_synth_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .internal_fast_osc(internal_fast_osc),
    .logic_cell_one_output(logic_cell_one_output), .synth_out(synth_out),
    .synth_pin_out(synth_pin_out), .synth_pin_oe(synth_pin_oe),
    .overflow_irq(overflow_irq), .keep_fast_osc_on(keep_fast_osc_on));
  pfs_far_side pfs_far_side_i (.pclk(pclk), .presetn(presetn),
    .internal_fast_osc(internal_fast_osc), .logic_cell_one_output(logic_cell_one_output));
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : close_out
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 20) begin
      n++;
      @(posedge pclk);
    end
    if (n == 20) begin
      `CHK(pready, 1'b1)
      close_out();
    end
    rd_q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    xfer(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    xfer(1'b0, a, 8'h00);
    `CHK(rd_q, {24'h0, e})
  endtask : rd
  task automatic idle(input int n);
    repeat (n) @(negedge pclk);
  endtask : idle
  // a 32-cycle window holds whole output periods, so counts do not depend on phase
  task automatic measure;
    logic last;
    tog = 0;
    act = 0;
    idle(16);
    last = synth_out;
    repeat (32) begin
      @(negedge pclk);
      tog += int'(synth_out !== last);
      act += int'(synth_out === 1'b1);
      last = synth_out;
    end
  endtask : measure
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 11; i++) begin
      rd(8'(i * 4), 8'h00);
    end
    rd(8'h2c, 8'h00);
    `CHK(err, 1'b1)
    $display("test reset_values done");
    wr(PFS_OFF_ACCUM_LOW, 8'h45);
    wr(PFS_OFF_ACCUM_HIGH, 8'h23);
    wr(PFS_OFF_ACCUM_UPPER, 8'hf1);
    wr(PFS_OFF_INCR_UPPER, 8'hf8);
    wr(PFS_OFF_SYNTH_CONTROL, 8'h20);
    idle(8);
    rd(PFS_OFF_ACCUM_LOW, 8'h45);
    rd(PFS_OFF_ACCUM_HIGH, 8'h23);
    rd(PFS_OFF_ACCUM_UPPER, 8'h01);
    rd(PFS_OFF_INCR_UPPER, 8'h08);
    rd(PFS_OFF_SYNTH_CONTROL, 8'h00);
    wr(PFS_OFF_SYNTH_CONTROL, 8'h10);
    idle(4);
    `CHK(synth_out, 1'b1)
    rd(PFS_OFF_SYNTH_CONTROL, 8'h30);
    $display("test disabled_access done");
    wr(PFS_OFF_SYNTH_CONTROL, 8'h80);
    for (int k = 0; k < 4; k++) begin
      wr(PFS_OFF_SYNTH_CLOCK_CONFIG, 8'h08 | 8'(k));
      measure();
      `CHK(tog, src_tog[k])
      `CHK(keep_fast_osc_on, k == 0)
      `CHK(synth_pin_oe, 1'b1)
    end
    wr(PFS_OFF_SYNTH_CLOCK_CONFIG, 8'h01);
    wr(PFS_OFF_INCR_UPPER, 8'h04);
    wr(PFS_OFF_INCR_HIGH, 8'h00);
    measure();
    `CHK(tog, 16)
    wr(PFS_OFF_INCR_LOW, 8'h00);
    measure();
    `CHK(tog, 8)
    $display("test fixed_duty done");
    rd(PFS_OFF_PERIPH_IRQ_REQUEST_2, 8'h01);
    `CHK(overflow_irq, 1'b0)
    wr(PFS_OFF_PERIPH_IRQ_ENABLE_2, 8'h01);
    wr(PFS_OFF_IRQ_CONTROL, 8'hc0);
    idle(2);
    `CHK(overflow_irq, 1'b1)
    wr(PFS_OFF_IRQ_CONTROL, 8'h80);
    idle(2);
    `CHK(overflow_irq, 1'b0)
    wr(PFS_OFF_SYNTH_CLOCK_CONFIG, 8'h03);
    wr(PFS_OFF_PERIPH_IRQ_REQUEST_2, 8'h00);
    idle(8);
    rd(PFS_OFF_PERIPH_IRQ_REQUEST_2, 8'h00);
    wr(PFS_OFF_IRQ_CONTROL, 8'hc0);
    wr(PFS_OFF_SYNTH_CONTROL, 8'h90);
    idle(2);
    rd(PFS_OFF_PERIPH_IRQ_REQUEST_2, 8'h01);
    `CHK(overflow_irq, 1'b1)
    wr(PFS_OFF_SYNTH_CONTROL, 8'h10);
    idle(2);
    `CHK(overflow_irq, 1'b0)
    rd(PFS_OFF_PERIPH_IRQ_REQUEST_2, 8'h01);
    wr(PFS_OFF_IRQ_CONTROL, 8'h00);
    $display("test interrupts done");
    wr(PFS_OFF_INCR_UPPER, 8'h02);
    wr(PFS_OFF_INCR_LOW, 8'h00);
    for (int w = 0; w < 3; w++) begin
      for (int p = 0; p < 2; p++) begin
        wr(PFS_OFF_SYNTH_CLOCK_CONFIG, 8'(w * 32 + 1));
        wr(PFS_OFF_SYNTH_CONTROL, 8'(8'h81 + p * 16));
        measure();
        `CHK(act, p ? 32 - (4 << w) : 4 << w)
      end
    end
    $display("test pulse_mode done");
    close_out();
  end
endmodule : phase_accum_freq_synth_tb_top
